/* File: btd_defs.svh */
// Constants for the bus-cycle termination and address-decode block.
// Assumes includers use these names for field slicing and timing only.
//
// Contract
// - Async ack used only after internal synchronizer.
// - Read data captured when synchronized ack asserts.
// - Write data driven until synchronized ack edge.
// - Async ack ignored for DRAM accesses.
// - Sync ack ignored for own DRAM accesses.
// - External-master region ack from waits and auto-ack.
// - External-master DRAM access gets driven sync ack.
// - Error ack aborts cycle, beats both acks.
// - Error ack recognized one clock after async ack.
// - Error ack ignored during DRAM accesses.
// - Double bus fault halts until reset.
// - Outputs on rising edge; row/column strobes falling.
// - Inputs synchronous except level, reset-in, async ack.
// - Driven sync ack negated one cycle before release.
// - Decode order: selects 0-7, DRAM 0-1, default.
// - Default region asserts no select or DRAM strobes.
// - Port size, auto-ack, waits from matched region; DRAM waits from DRAM timing control.
// - Transfer start lasts one clock per cycle.
`ifndef BTD_DEFS_SVH
`define BTD_DEFS_SVH

// ----------------------------------------------------------------
// Region control word layout
// ----------------------------------------------------------------
`define BTD_CTL_VALID  0
`define BTD_CTL_AUTO   1
`define BTD_CTL_EXT_MASTER_AUTO_ACK   2
`define BTD_CTL_PS_LO  3
`define BTD_CTL_PS_HI  4
`define BTD_CTL_WS_LO  5
`define BTD_CTL_WS_HI  8
`define BTD_CTL_W      9

// ----------------------------------------------------------------
// Address compare window and timing
// ----------------------------------------------------------------
`define BTD_MATCH_LO   12
`define BTD_MATCH_W    16
`define BTD_WAIT_W     4
`define BTD_SYNC_RST   1'b1

`endif

/* File: btd_pkg.sv */
// Types shared by the termination and decode block.
// Assumes btd_defs.svh is compiled alongside.
`include "btd_defs.svh"

package btd_pkg;

  typedef enum logic [1:0] {
    BTD_CS,
    BTD_DRAM,
    BTD_DEF
  } btd_kind_t;

  typedef enum {
    S_IDLE,
    S_ACC,
    S_EXT,
    S_EXT_ACK,
    S_EXT_NEG,
    S_HALT
  } btd_state_t;

  typedef struct packed {
    btd_kind_t               kind;
    logic [2:0]              idx;
    logic [1:0]              ps;
    logic                    aa;
    logic                    ext_master_auto_ack;
    logic [`BTD_WAIT_W-1:0]  ws;
  } btd_dec_t;

endpackage

/* File: btd_slave_model.sv */
// Behavioural slave answering on the external bus.
// Assumes active-low selects; acks read as high when released (pull-ups).
`timescale 1ns/10ps
module btd_slave_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [7:0]  sel_n_i,
  output logic             async_n_o,
  output logic             sync_n_o,
  output logic             err_n_o,
  output logic [31:0]      data_o
);
  // Mode 0 silent, 1 sync ack, 2 async ack, 3 async then late error, 4 error
  localparam logic [31:0] PAT = 32'hA5C3_0F12;
  logic [2:0] cnt;
  always_ff @(posedge clk_i) begin
    cnt <= (&sel_n_i) ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
  end
  assign sync_n_o  = !(mode_i == 3'h1 && cnt == 3'h1);
  // Async ack held two cycles so the synchronizer cannot miss it
  assign async_n_o = !(mode_i[1] && (cnt == 3'h1 || cnt == 3'h2));
  assign err_n_o   = !((mode_i == 3'h4 && cnt == 3'h1) || (mode_i == 3'h3 && cnt == 3'h2));
  // Data follows the select one cycle late, else inverted so stale captures show
  assign data_o    = (cnt != 3'h0) ? PAT : ~PAT;
endmodule // btd_slave_model

/* File: btd_term_decode.sv */
// Bus-cycle termination and address decode for the external bus.
// Assumes one bus clock; region settings are held static by software.
`timescale 1ns/10ps
`include "btd_defs.svh"

module btd_term_decode
  import btd_pkg::*;
#(
  parameter int ADDR_W = 28,
  parameter int DATA_W = 32,
  parameter int N_CS   = 8,
  parameter int N_DRAM = 2
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Core side
  input  wire logic                        cyc_req_i,
  input  wire logic [ADDR_W-1:0]           cyc_addr_i,
  input  wire logic                        cyc_write_i,
  input  wire logic [DATA_W-1:0]           cyc_wdata_i,
  input  wire logic                        fault_active_i,
  output logic                             cyc_busy_o,
  output logic                             cyc_done_o,
  output logic                             cyc_error_o,
  output logic [DATA_W-1:0]                cyc_rdata_o,
  output logic [1:0]                       port_size_o,
  output logic                             halted_o,
  // External bus
  input  wire logic                        ext_master_i,
  input  wire logic                        transfer_start_n_i,
  input  wire logic [ADDR_W-1:0]           bus_addr_i,
  input  wire logic                        async_xfer_ack_n_i,
  input  wire logic                        sync_xfer_ack_n_i,
  output logic                             sync_xfer_ack_n_o,
  output logic                             sync_xfer_ack_oe_o,
  input  wire logic                        xfer_error_ack_n_i,
  input  wire logic [DATA_W-1:0]           data_i,
  output logic [DATA_W-1:0]                data_o,
  output logic                             data_oe_o,
  output logic [N_CS-1:0]                  region_sel_n_o,
  output logic [N_DRAM-1:0]                row_strobe_n_o,
  output logic [3:0]                       col_strobe_n_o,
  // Asynchronous level inputs
  input  wire logic [2:0]                  irq_priority_level_n_i,
  input  wire logic                        reset_in_n_i,
  output logic [2:0]                       irq_level_sync_n_o,
  output logic                             reset_in_sync_n_o,
  // Region settings
  input  wire logic [N_CS*`BTD_MATCH_W-1:0]   region_select_base_i,
  input  wire logic [N_CS*`BTD_MATCH_W-1:0]   region_select_mask_i,
  input  wire logic [N_CS*`BTD_CTL_W-1:0]     region_select_ctrl_i,
  input  wire logic [N_DRAM*`BTD_MATCH_W-1:0] dram_bank_base_i,
  input  wire logic [N_DRAM*`BTD_MATCH_W-1:0] dram_bank_mask_i,
  input  wire logic [N_DRAM*`BTD_CTL_W-1:0]   dram_bank_ctrl_i,
  input  wire logic [`BTD_CTL_W-1:0]          default_region_ctrl_i,
  input  wire logic [`BTD_WAIT_W-1:0]         dram_timing_ctrl_i
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The select index is three bits wide, so at most eight selects fit.
  if (N_CS < 1 || N_CS > 8) begin : g_chk_cs
    $error("N_CS must lie in 1..8");
  end
  if (N_DRAM < 1 || N_DRAM > 8) begin : g_chk_dram
    $error("N_DRAM must lie in 1..8");
  end
  if (ADDR_W < `BTD_MATCH_LO + `BTD_MATCH_W) begin : g_chk_addr
    $error("ADDR_W too narrow for the compare window");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic btd_dec_t fill(input btd_kind_t k, input logic [2:0] i,
                                    input logic [`BTD_CTL_W-1:0] c);
    btd_dec_t d;
    d.kind = k;
    d.idx  = i;
    d.ps   = c[`BTD_CTL_PS_HI:`BTD_CTL_PS_LO];
    d.aa   = c[`BTD_CTL_AUTO];
    d.ext_master_auto_ack = c[`BTD_CTL_EXT_MASTER_AUTO_ACK];
    d.ws   = c[`BTD_CTL_WS_HI:`BTD_CTL_WS_LO];
    return d;
  endfunction

  // Lowest index wins; walking downward lets earlier entries overwrite.
  function automatic btd_dec_t decode(input logic [ADDR_W-1:0] a);
    logic [`BTD_MATCH_W-1:0] f;
    btd_dec_t                d;
    f = a[`BTD_MATCH_LO +: `BTD_MATCH_W];
    d = fill(BTD_DEF, 3'h0, default_region_ctrl_i);
    for (int j = N_DRAM - 1; j >= 0; j--) begin
      if (dram_bank_ctrl_i[j*`BTD_CTL_W + `BTD_CTL_VALID] &&
          ((f ^ dram_bank_base_i[j*`BTD_MATCH_W +: `BTD_MATCH_W]) &
           ~dram_bank_mask_i[j*`BTD_MATCH_W +: `BTD_MATCH_W]) == '0) begin
        d = fill(BTD_DRAM, 3'(j), dram_bank_ctrl_i[j*`BTD_CTL_W +: `BTD_CTL_W]);
      end
    end
    for (int j = N_CS - 1; j >= 0; j--) begin
      if (region_select_ctrl_i[j*`BTD_CTL_W + `BTD_CTL_VALID] &&
          ((f ^ region_select_base_i[j*`BTD_MATCH_W +: `BTD_MATCH_W]) &
           ~region_select_mask_i[j*`BTD_MATCH_W +: `BTD_MATCH_W]) == '0) begin
        d = fill(BTD_CS, 3'(j), region_select_ctrl_i[j*`BTD_CTL_W +: `BTD_CTL_W]);
      end
    end
    return d;
  endfunction

  // The device drives the sync ack for DRAM always, otherwise on auto-ack.
  function automatic logic drives_ack(input btd_dec_t d);
    return (d.kind == BTD_DRAM) || d.ext_master_auto_ack;
  endfunction

  // ----------------------------------------------------------------
  // Synchronizers
  // ----------------------------------------------------------------
  logic       ack_s1;
  logic       ack_s2;
  logic [2:0] irq_s1;
  logic       rst_s1;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_s1 <= `BTD_SYNC_RST;
      ack_s2 <= `BTD_SYNC_RST;
    end else begin
      ack_s1 <= async_xfer_ack_n_i;
      ack_s2 <= ack_s1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_s1             <= 3'h7;
      irq_level_sync_n_o <= 3'h7;
      rst_s1             <= `BTD_SYNC_RST;
      reset_in_sync_n_o  <= `BTD_SYNC_RST;
    end else begin
      irq_s1             <= irq_priority_level_n_i;
      irq_level_sync_n_o <= irq_s1;
      rst_s1             <= reset_in_n_i;
      reset_in_sync_n_o  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  btd_state_t             state;
  btd_state_t             next_state;
  btd_dec_t               cur;
  btd_dec_t               next_cur;
  logic                   wr;
  logic [`BTD_WAIT_W-1:0] wcnt;
  logic                   ws_done;
  logic                   dram_done;
  logic                   acc_ok;
  logic                   acc_err;
  logic                   ext_end;
  logic                   ext_start;

  assign ws_done   = (wcnt >= cur.ws);
  assign dram_done = (wcnt >= dram_timing_ctrl_i);
  // A low start strobe seen in idle while ext_master_i is high opens an external cycle; it lasts one clock.
  assign ext_start = ext_master_i && !transfer_start_n_i;

  always_comb begin
    acc_ok  = 1'b0;
    acc_err = 1'b0;
    if (state == S_ACC) begin
      if (cur.kind == BTD_DRAM) begin
        // DRAM cycles are timed here; the slave's acks and error do not count.
        acc_ok = dram_done;
      end else if (!xfer_error_ack_n_i) begin
        // Error is checked first, also in the cycle the synchronized ack lands.
        acc_err = 1'b1;
      end else begin
        // A synchronized ack left over from the previous cycle must not end this one.
        acc_ok = (!ack_s2 && wcnt >= `BTD_WAIT_W'(2)) || !sync_xfer_ack_n_i ||
                 (cur.aa && ws_done);
      end
    end
  end

  always_comb begin
    ext_end = 1'b0;
    if (state == S_EXT && !drives_ack(cur)) begin
      // Someone else terminates; follow the wire to know when it ends.
      ext_end = !sync_xfer_ack_n_i || !xfer_error_ack_n_i;
    end
  end

  always_comb begin
    next_state = state;
    next_cur   = cur;
    case (state)
      S_IDLE: begin
        if (ext_start) begin
          next_state = S_EXT;
          next_cur   = decode(bus_addr_i);
        end else if (cyc_req_i && !ext_master_i) begin
          next_state = S_ACC;
          next_cur   = decode(cyc_addr_i);
        end
      end
      S_ACC: begin
        if (acc_err && fault_active_i) begin
          next_state = S_HALT;
        end else if (acc_ok || acc_err) begin
          next_state = S_IDLE;
        end
      end
      S_EXT: begin
        if (drives_ack(cur)) begin
          if ((cur.kind == BTD_DRAM) ? dram_done : ws_done) begin
            next_state = S_EXT_ACK;
          end
        end else if (ext_end) begin
          next_state = S_IDLE;
        end
      end
      S_EXT_ACK: next_state = S_EXT_NEG;
      S_EXT_NEG: next_state = S_IDLE;
      S_HALT:    next_state = S_HALT;
      default:   next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      cur   <= '{kind: BTD_DEF, idx: 3'h0, ps: 2'h0, aa: 1'b0, ext_master_auto_ack: 1'b0,
                 ws: '0};
    end else begin
      state <= next_state;
      cur   <= next_cur;
    end
  end

  // Wait counter restarts on every cycle entry and saturates.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wcnt <= '0;
    end else if (state == S_IDLE) begin
      wcnt <= '0;
    end else if (wcnt != '1) begin
      wcnt <= wcnt + `BTD_WAIT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Core answers and data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cyc_done_o  <= 1'b0;
      cyc_error_o <= 1'b0;
      cyc_rdata_o <= '0;
      halted_o    <= 1'b0;
      port_size_o <= 2'h0;
    end else begin
      cyc_done_o  <= acc_ok;
      cyc_error_o <= acc_err;
      if (acc_ok && !wr) begin
        cyc_rdata_o <= data_i;
      end
      if (next_state == S_HALT) begin
        halted_o <= 1'b1;
      end
      port_size_o <= next_cur.ps;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr        <= 1'b0;
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else begin
      if (state == S_IDLE && next_state == S_ACC) begin
        wr     <= cyc_write_i;
        data_o <= cyc_wdata_i;
      end
      // Released at the very edge that ends the cycle, not before.
      data_oe_o <= (next_state == S_ACC) &&
                   ((state == S_IDLE) ? cyc_write_i : wr);
    end
  end

  assign cyc_busy_o = (state != S_IDLE);

  // ----------------------------------------------------------------
  // Driven sync ack for external masters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_xfer_ack_n_o  <= 1'b1;
      sync_xfer_ack_oe_o <= 1'b0;
    end else begin
      sync_xfer_ack_n_o  <= (next_state != S_EXT_ACK);
      // One negated cycle after the ack avoids a floating slow rise.
      sync_xfer_ack_oe_o <= (next_state == S_EXT_ACK) ||
                            (next_state == S_EXT_NEG) ||
                            (next_state == S_EXT && drives_ack(next_cur));
    end
  end

  // ----------------------------------------------------------------
  // Select and DRAM strobes
  // ----------------------------------------------------------------
  logic dram_act;

  assign dram_act = (cur.kind == BTD_DRAM) && ((state == S_ACC) || (state == S_EXT));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      region_sel_n_o <= '1;
    end else begin
      for (int i = 0; i < N_CS; i++) begin
        region_sel_n_o[i] <= !(((next_state == S_ACC) || (next_state == S_EXT)) &&
                               next_cur.kind == BTD_CS &&
                               next_cur.idx == 3'(i));
      end
    end
  end

  // Falling-edge strobes give the address half a clock of setup.
  always_ff @(negedge clk_i) begin
    if (!rst_n_i) begin
      row_strobe_n_o <= '1;
      col_strobe_n_o <= 4'hF;
    end else begin
      for (int i = 0; i < N_DRAM; i++) begin
        row_strobe_n_o[i] <= !(dram_act && cur.idx == 3'(i));
      end
      // Byte-lane steering is not done here: all column lanes move together.
      col_strobe_n_o <= (dram_act && wcnt != '0) ? 4'h0 : 4'hF;
    end
  end

endmodule // btd_term_decode

/* File: btd_term_decode_chk.sv */
// Concurrent checks on the termination and decode block's ports.
// Assumes the default widths and a single bus clock with sync reset.
`timescale 1ns/10ps
module btd_term_decode_chk #(
  parameter int N_CS   = 8,
  parameter int N_DRAM = 2
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              cyc_busy_o,
  input wire logic              cyc_done_o,
  input wire logic              cyc_error_o,
  input wire logic              halted_o,
  input wire logic              ext_master_i,
  input wire logic              transfer_start_n_i,
  input wire logic              async_xfer_ack_n_i,
  input wire logic              xfer_error_ack_n_i,
  input wire logic              sync_xfer_ack_n_o,
  input wire logic              sync_xfer_ack_oe_o,
  input wire logic [N_CS-1:0]   region_sel_n_o,
  input wire logic [N_DRAM-1:0] row_strobe_n_o,
  input wire logic [2:0]        irq_priority_level_n_i,
  input wire logic [2:0]        irq_level_sync_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_err_wins: assert property (cyc_error_o |-> !cyc_done_o && $past(!xfer_error_ack_n_i))
    else $error("error pulse without error ack or with done");
  a_async_sync: assert property (($fell(async_xfer_ack_n_i) && cyc_busy_o) |-> !cyc_done_o[*3])
    else $error("async ack used before synchronizer");
  a_async_lands: assert property (($fell(async_xfer_ack_n_i) && cyc_busy_o)
    |-> ##[2:3] (cyc_done_o || cyc_error_o))
    else $error("synchronized ack did not end the cycle");
  a_ack_once: assert property ((sync_xfer_ack_oe_o && !sync_xfer_ack_n_o)
    |=> sync_xfer_ack_oe_o && sync_xfer_ack_n_o ##1 !sync_xfer_ack_oe_o)
    else $error("driven ack not negated one cycle before release");
  a_ack_start: assert property ($rose(sync_xfer_ack_oe_o)
    |-> $past(!transfer_start_n_i) && ext_master_i)
    else $error("ack driven without external start");
  a_halt_stick: assert property (halted_o |=> halted_o)
    else $error("halt left without reset");
  a_halt_quiet: assert property (halted_o |-> !cyc_done_o && (&region_sel_n_o))
    else $error("activity while halted");
  a_irq_sync: assert property (($past(rst_n_i) && $past(rst_n_i, 2))
    |-> irq_level_sync_n_o == $past(irq_priority_level_n_i, 2))
    else $error("level input not two-stage synchronized");
  a_row_nocs: assert property (!(&row_strobe_n_o) |-> (&region_sel_n_o))
    else $error("select and row strobe together");
endmodule // btd_term_decode_chk

bind btd_term_decode btd_term_decode_chk #(.N_CS(N_CS), .N_DRAM(N_DRAM)) u_chk (.*);

/* File: btd_term_decode_test.sv */
// Self-checking bench for the termination and decode block.
// Assumes the slave model on the bus and default design parameters.
`timescale 1ns/10ps
`include "btd_defs.svh"
module btd_term_decode_test;
  import btd_pkg::*;
  `define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin num_errors++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
  localparam logic [31:0] PAT = 32'hA5C3_0F12;
  logic clk_i, rst_n_i, cyc_req_i, cyc_write_i, fault_active_i, cyc_busy_o, cyc_done_o;
  logic cyc_error_o, halted_o, ext_master_i, transfer_start_n_i, async_xfer_ack_n_i;
  logic sync_xfer_ack_n_i, sync_xfer_ack_n_o, sync_xfer_ack_oe_o, xfer_error_ack_n_i;
  logic data_oe_o, reset_in_n_i, reset_in_sync_n_o, sync_slv_n;
  logic [27:0]  cyc_addr_i, bus_addr_i;
  logic [31:0]  cyc_wdata_i, cyc_rdata_o, data_i, data_o, dram_bank_base_i, dram_bank_mask_i;
  logic [1:0]   port_size_o, row_strobe_n_o;
  logic [7:0]   region_sel_n_o;
  logic [3:0]   col_strobe_n_o, dram_timing_ctrl_i;
  logic [2:0]   irq_priority_level_n_i, irq_level_sync_n_o, mode;
  logic [127:0] region_select_base_i, region_select_mask_i;
  logic [71:0]  region_select_ctrl_i;
  logic [17:0]  dram_bank_ctrl_i;
  logic [8:0]   default_region_ctrl_i;
  int           num_errors, n_compared;

  btd_term_decode u_dut (.*);
  btd_slave_model u_slv (.clk_i(clk_i), .mode_i(mode), .sel_n_i(region_sel_n_o),
    .async_n_o(async_xfer_ack_n_i), .sync_n_o(sync_slv_n), .err_n_o(xfer_error_ack_n_i),
    .data_o(data_i));
  // Shared ack wire: device drives when enabled, slave or pull-up otherwise
  assign sync_xfer_ack_n_i = sync_xfer_ack_oe_o ? sync_xfer_ack_n_o : sync_slv_n;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask

  // One core cycle; lat counts cycles from the request to the end pulse
  task automatic acc(input string nm, input logic [27:0] a, input logic w, input logic [2:0] m,
                     input logic e, input int lat, input logic [7:0] sel, input logic [1:0] ps,
                     input logic [1:0] row);
    int n;
    logic [7:0] s;
    logic [1:0] r;
    mode = m; s = 8'hFF; r = 2'h3; n = 1;
    cyc_addr_i = a; cyc_write_i = w; cyc_req_i = 1'b1;
    @(negedge clk_i);
    cyc_req_i = 1'b0;
    `CHK("port size", ps, port_size_o)
    `CHK("busy", 1'b1, cyc_busy_o)
    if (w) `CHK("write data", cyc_wdata_i, data_o)
    if (w) `CHK("write drive", 1'b1, data_oe_o)
    while (!(cyc_done_o || cyc_error_o) && n < 40) begin
      s &= region_sel_n_o; r &= row_strobe_n_o;
      @(negedge clk_i);
      n++;
    end
    if (n == 40) begin num_errors++; stop_test(); end
    `CHK("latency", lat, n)
    `CHK("error", e, cyc_error_o)
    `CHK("selects", sel, s)
    `CHK("row strobes", row, r)
    `CHK("write release", 1'b0, data_oe_o)
    if (!w && !e) `CHK("read data", (sel == 8'hFF) ? ~PAT : PAT, cyc_rdata_o)
    $display("test %s done", nm);
  endtask

  // External master start; the device must drive the ack low at cycle lat
  task automatic ext(input logic [27:0] a, input int lat);
    int n;
    n = 1;
    ext_master_i = 1'b1; transfer_start_n_i = 1'b0; bus_addr_i = a;
    @(negedge clk_i);
    transfer_start_n_i = 1'b1;
    while (!(sync_xfer_ack_oe_o && !sync_xfer_ack_n_o) && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("ext ack", lat, n)
    repeat (3) @(negedge clk_i);
    `CHK("ack released", 1'b0, sync_xfer_ack_oe_o)
    ext_master_i = 1'b0;
    $display("test ext %0h done", a);
  endtask

  initial begin
    num_errors = 0; n_compared = 0; mode = 3'h0;
    rst_n_i = 1'b0; cyc_req_i = 1'b0; cyc_write_i = 1'b0; fault_active_i = 1'b0;
    cyc_addr_i = '0; bus_addr_i = '0; cyc_wdata_i = 32'h1234_ABCD; ext_master_i = 1'b0;
    transfer_start_n_i = 1'b1; irq_priority_level_n_i = 3'h7; reset_in_n_i = 1'b1;
    // Selects 0 and 2 overlap on purpose; the lower index must win
    region_select_base_i = {80'h0, 16'h0001, 16'h0002, 16'h0001};
    region_select_mask_i = '0;
    region_select_ctrl_i = {45'h0, 9'h01B, 9'h009, 9'h053};
    dram_bank_base_i = {16'h0, 16'h0003}; dram_bank_mask_i = '0;
    dram_bank_ctrl_i = {9'h0, 9'h011}; default_region_ctrl_i = 9'h026;
    dram_timing_ctrl_i = 4'h1;
    do_reset();
    acc("cs0 auto", 28'h0001000, 1'b0, 3'h0, 1'b0, 4, 8'hFE, 2'h2, 2'h3);
    acc("sync wr", 28'h0002000, 1'b1, 3'h1, 1'b0, 3, 8'hFD, 2'h1, 2'h3);
    acc("async rd", 28'h0002000, 1'b0, 3'h2, 1'b0, 5, 8'hFD, 2'h1, 2'h3);
    acc("async wr", 28'h0002000, 1'b1, 3'h2, 1'b0, 5, 8'hFD, 2'h1, 2'h3);
    acc("late err", 28'h0002000, 1'b0, 3'h3, 1'b1, 4, 8'hFD, 2'h1, 2'h3);
    acc("err", 28'h0002000, 1'b0, 3'h4, 1'b1, 3, 8'hFD, 2'h1, 2'h3);
    acc("dram", 28'h0003000, 1'b0, 3'h2, 1'b0, 3, 8'hFF, 2'h2, 2'h2);
    acc("default", 28'h0005000, 1'b0, 3'h0, 1'b0, 3, 8'hFF, 2'h0, 2'h3);
    ext(28'h0003000, 3);
    ext(28'h0005000, 3);
    irq_priority_level_n_i = 3'h2; reset_in_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("irq sync", 3'h2, irq_level_sync_n_o)
    `CHK("reset in sync", 1'b0, reset_in_sync_n_o)
    fault_active_i = 1'b1; mode = 3'h4; cyc_addr_i = 28'h0002000; cyc_req_i = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHK("halted", 1'b1, halted_o)
    do_reset();
    `CHK("halt cleared", 1'b0, halted_o)
    cyc_req_i = 1'b0; fault_active_i = 1'b0;
    acc("after halt", 28'h0001000, 1'b0, 3'h0, 1'b0, 4, 8'hFE, 2'h2, 2'h3);
    stop_test();
  end
endmodule // btd_term_decode_test
